// [src/ide_bm_pkg.sv]
// Purpose: Shared constants and carriers for the two-channel bus-master IDE control block.
// Assumes: Byte offsets inside the 16-byte I/O window; 8-bit command and status registers, 32-bit descriptor pointers.
// Notes: Rules that this block and its partners keep are listed below.
// Contract
// - Decode a 16-byte I/O window; accept byte, word and dword accesses.
// - Two channels; command registers at 00h and 08h, status beside them.
// - Command bit 3 picks direction: 0 memory reads, 1 memory writes.
// - Writing command bit 0 to 1 starts; data moves only while it is 1.
// - Writing 0 stops and discards state; restart begins a fresh operation.
// - Stop while active and interrupt flag clear aborts; drive data may drop.
// - Status bit 7 always reads 0.
// - Status bits 6 and 5 are plain storage with no hardware effect.
// - Status bit 2 sets on a drive interrupt and stays until cleared.
// - Interrupt set with active clear means all data has been delivered.
// - Status bits 2 and 1 clear on writing 1; writing 0 leaves them.
// - Primary watches IRQ14; secondary watches board line or IRQ15 by route bit 5.
// - Clearing while the line is still high keeps flag 0 until a new edge.
// - Status bit 1 sets on target or master abort during own transfers.
// - Status bit 0 is read-only and sets when the start bit is written 1 while it holds 0.
// - Active clears after the last transfer of an end-of-table region.
// - Active also clears on start bit written 0 or error flag set.
// - Active reading 0 means drive data is visible in memory unless aborted.
// - Descriptor pointer at 04h and 0Ch; dword aligned, within 4 Kbyte.
// - Interrupt 1 with active 1 means drive finished with descriptors left.
// - Interrupt 0 with active 0 means error, or descriptors too short.
package ide_bm_pkg;

  // Window layout
  localparam int WINDOW_BYTES = 16;
  localparam logic [3:0] CMD_PRI_OFS = 4'h0;
  localparam logic [3:0] STS_PRI_OFS = 4'h2;
  localparam logic [3:0] DTP_PRI_OFS = 4'h4;
  localparam logic [3:0] CMD_SEC_OFS = 4'h8;
  localparam logic [3:0] STS_SEC_OFS = 4'hA;
  localparam logic [3:0] DTP_SEC_OFS = 4'hC;

  // Command fields
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_DIR_BIT = 3;
  localparam logic [7:0] CMD_WMASK = 8'h09;

  // Status fields
  localparam int STS_ACT_BIT = 0;
  localparam int STS_ERR_BIT = 1;
  localparam int STS_IRQ_BIT = 2;
  localparam int STS_CAP0_BIT = 5;
  localparam int STS_CAP1_BIT = 6;
  localparam logic [7:0] STS_CAP_MASK = 8'h60;

  // Descriptor pointer keeps address bits 31:2 only
  localparam logic [31:0] DTP_MASK = 32'hFFFF_FFFC;

  // Reset values
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] STS_RESET = 8'h00;
  localparam logic [31:0] DTP_RESET = 32'h0000_0000;

  // Routing register bit that moves the secondary watch to IRQ15
  localparam int ROUTE_IRQ15_BIT = 5;

  // Control handed to the descriptor engine of one channel
  typedef struct packed {
    logic dir;
    logic run;
    logic start;
    logic abort;
  } engine_ctl_t;

  // Events reported by the descriptor engine of one channel
  typedef struct packed {
    logic eot_done;
    logic pci_abort;
    logic flushed;
  } engine_evt_t;

endpackage : ide_bm_pkg

// [src/ide_bm_ctrl.sv]
// Purpose: Command, status and descriptor pointer registers of a two-channel IDE DMA engine.
// Assumes: I/O window base comes from a config-space base register outside this block.
// Notes: Read data returns one cycle after the read strobe; writes act in their cycle.
`timescale 1ns/1ns
`default_nettype none

module ide_bm_ctrl
  import ide_bm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // I/O window access
  input wire logic [31:4] window_base,
  input wire logic [31:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic [31:0] io_wdata,
  output logic io_hit,
  output logic [31:0] io_rdata,
  output logic io_rvalid,
  // Drive interrupt lines and routing
  input wire logic irq14,
  input wire logic irq15,
  input wire logic board_interrupt_line_zero,
  input wire logic [7:0] board_route,
  // Descriptor engine side, index 0 primary, 1 secondary
  input wire engine_evt_t [1:0] engine_evt,
  output engine_ctl_t [1:0] engine_ctl,
  output logic [1:0][31:0] desc_base
);

  logic [1:0][7:0] cmd_reg;
  logic [1:0][7:0] sts_reg;
  logic [1:0][31:0] dtp_reg;
  logic [1:0] irq_prev_reg;
  logic [1:0] eot_pending_reg;
  logic [1:0] watch_line;
  logic [1:0] irq_edge;
  logic [1:0] start_wr;
  logic [1:0] stop_wr;
  logic [1:0] err_set;
  logic [1:0] irq_clr;
  logic [1:0] err_clr;
  logic [31:0] rd_word;
  logic [31:0] io_rdata_reg;
  logic io_rvalid_reg;

  // Window decode on address bits 31:4; address bits 3:2 pick the dword and byte enables pick the byte register
  assign io_hit = (io_addr[31:4] == window_base);

  // Secondary watches IRQ15 only when the routing bit asks for it
  assign watch_line[0] = irq14;
  assign watch_line[1] = board_route[ROUTE_IRQ15_BIT] ? irq15 : board_interrupt_line_zero;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      localparam logic [3:0] CMD_OFS = (ch == 0) ? CMD_PRI_OFS : CMD_SEC_OFS;
      localparam logic [3:0] STS_OFS = (ch == 0) ? STS_PRI_OFS : STS_SEC_OFS;
      localparam logic [3:0] DTP_OFS = (ch == 0) ? DTP_PRI_OFS : DTP_SEC_OFS;
      localparam int CMD_LANE = int'(CMD_OFS[1:0]);
      localparam int STS_LANE = int'(STS_OFS[1:0]);

      logic cmd_we;
      logic sts_we;
      logic dtp_hit;
      logic [7:0] cmd_wbyte;
      logic [7:0] sts_wbyte;
      logic act_next;

      // Each byte register reacts only to its own enabled lane
      assign cmd_we = io_hit && io_write && (io_addr[3:2] == CMD_OFS[3:2])
                      && io_be[CMD_LANE];
      assign sts_we = io_hit && io_write && (io_addr[3:2] == STS_OFS[3:2])
                      && io_be[STS_LANE];
      assign dtp_hit = io_hit && io_write && (io_addr[3:2] == DTP_OFS[3:2]);
      assign cmd_wbyte = io_wdata[8*CMD_LANE +: 8];
      assign sts_wbyte = io_wdata[8*STS_LANE +: 8];

      // Start only on a 0 to 1 change, so a repeated write of 1 does not revive a dead run
      assign start_wr[ch] = cmd_we && cmd_wbyte[CMD_RUN_BIT] && !cmd_reg[ch][CMD_RUN_BIT];
      assign stop_wr[ch] = cmd_we && !cmd_wbyte[CMD_RUN_BIT];
      assign irq_edge[ch] = watch_line[ch] && !irq_prev_reg[ch];
      assign err_set[ch] = engine_evt[ch].pci_abort && cmd_reg[ch][CMD_RUN_BIT];
      assign irq_clr[ch] = sts_we && sts_wbyte[STS_IRQ_BIT];
      assign err_clr[ch] = sts_we && sts_wbyte[STS_ERR_BIT];

      // Command register: only run and direction bits hold state
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmd_reg[ch] <= CMD_RESET;
        end else if (cmd_we) begin
          cmd_reg[ch] <= cmd_wbyte & CMD_WMASK;
        end
      end

      // Interrupt line history for edge detection
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          irq_prev_reg[ch] <= 1'b0;
        end else begin
          irq_prev_reg[ch] <= watch_line[ch];
        end
      end

      // End of table is held until buffered drive data has reached memory
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          eot_pending_reg[ch] <= 1'b0;
        end else if (stop_wr[ch] || err_set[ch] || start_wr[ch]) begin
          eot_pending_reg[ch] <= 1'b0;
        end else if (engine_evt[ch].eot_done && sts_reg[ch][STS_ACT_BIT]
                     && !engine_evt[ch].flushed) begin
          eot_pending_reg[ch] <= 1'b1;
        end else if (engine_evt[ch].flushed) begin
          eot_pending_reg[ch] <= 1'b0;
        end
      end

      // Active flag: errors and stops beat the start set, flush gates the end of table
      always_comb begin
        act_next = sts_reg[ch][STS_ACT_BIT];
        if (start_wr[ch]) begin
          act_next = 1'b1;
        end
        if ((eot_pending_reg[ch] || engine_evt[ch].eot_done) && engine_evt[ch].flushed) begin
          act_next = 1'b0;
        end
        if (stop_wr[ch] || err_set[ch]) begin
          act_next = 1'b0;
        end
      end

      // Status register; hardware sets win over a same-cycle write-one clear
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sts_reg[ch] <= STS_RESET;
        end else begin
          sts_reg[ch][7] <= 1'b0;
          sts_reg[ch][4:3] <= 2'b00;
          if (sts_we) begin
            sts_reg[ch][STS_CAP1_BIT:STS_CAP0_BIT] <= sts_wbyte[STS_CAP1_BIT:STS_CAP0_BIT];
          end
          if (irq_edge[ch]) begin
            sts_reg[ch][STS_IRQ_BIT] <= 1'b1;
          end else if (irq_clr[ch]) begin
            sts_reg[ch][STS_IRQ_BIT] <= 1'b0;
          end
          if (err_set[ch]) begin
            sts_reg[ch][STS_ERR_BIT] <= 1'b1;
          end else if (err_clr[ch]) begin
            sts_reg[ch][STS_ERR_BIT] <= 1'b0;
          end
          sts_reg[ch][STS_ACT_BIT] <= act_next;
        end
      end

      // Descriptor pointer, dword aligned; bits 1:0 are dropped
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dtp_reg[ch] <= DTP_RESET;
        end else if (dtp_hit) begin
          for (int b = 0; b < 4; b++) begin
            if (io_be[b]) begin
              dtp_reg[ch][8*b +: 8] <= io_wdata[8*b +: 8] & DTP_MASK[8*b +: 8];
            end
          end
        end
      end

      // Engine control: start is a fresh-operation pulse, abort only when drive unfinished
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          engine_ctl[ch] <= '0;
        end else begin
          engine_ctl[ch].run <= cmd_we ? cmd_wbyte[CMD_RUN_BIT]
                                       : cmd_reg[ch][CMD_RUN_BIT];
          engine_ctl[ch].dir <= cmd_we ? cmd_wbyte[CMD_DIR_BIT]
                                       : cmd_reg[ch][CMD_DIR_BIT];
          engine_ctl[ch].start <= start_wr[ch];
          engine_ctl[ch].abort <= stop_wr[ch] && sts_reg[ch][STS_ACT_BIT]
                                  && !sts_reg[ch][STS_IRQ_BIT];
        end
      end

      assign desc_base[ch] = dtp_reg[ch];
    end
  endgenerate

  // Read word assembly; lanes not enabled read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (io_addr[2] == 1'b0) begin
      rd_word = {8'h00, sts_reg[io_addr[3]], 8'h00, cmd_reg[io_addr[3]]};
    end else begin
      rd_word = dtp_reg[io_addr[3]];
    end
    for (int b = 0; b < 4; b++) begin
      if (!io_be[b]) begin
        rd_word[8*b +: 8] = 8'h00;
      end
    end
  end

  // Registered read return keeps the data outputs glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata_reg <= 32'h0000_0000;
      io_rvalid_reg <= 1'b0;
    end else begin
      io_rvalid_reg <= io_hit && io_read;
      if (io_hit && io_read) begin
        io_rdata_reg <= rd_word;
      end
    end
  end

  assign io_rdata = io_rdata_reg;
  assign io_rvalid = io_rvalid_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start_pri;
    start_wr[0] && !engine_evt[0].pci_abort;
  endsequence

  sequence s_stop_busy_pri;
    stop_wr[0] && sts_reg[0][STS_ACT_BIT] && !sts_reg[0][STS_IRQ_BIT];
  endsequence

  sequence s_start_sec;
    start_wr[1] && !engine_evt[1].pci_abort;
  endsequence

  sequence s_held_clear_pri;
    irq_clr[0] && !irq_edge[0] && watch_line[0] ##1 watch_line[0] [*2];
  endsequence

  start_sets_act_a: assert property (s_start_pri |=>
    sts_reg[0][STS_ACT_BIT] && engine_ctl[0].start && engine_ctl[0].run)
    else $error("start write did not raise active and start pulse");

  stop_clears_act_a: assert property (stop_wr[1] |=>
    !sts_reg[1][STS_ACT_BIT] && !engine_ctl[1].run)
    else $error("stop write left channel active");

  stop_abort_pulse_a: assert property (s_stop_busy_pri |=>
    engine_ctl[0].abort ##1 !engine_ctl[0].abort)
    else $error("abort pulse missing or too long");

  error_kills_act_a: assert property (err_set[1] |=>
    sts_reg[1][STS_ERR_BIT] && !sts_reg[1][STS_ACT_BIT])
    else $error("abort did not set error and clear active");

  irq_edge_sets_a: assert property (irq_edge[0] |=>
    sts_reg[0][STS_IRQ_BIT] ##1 (sts_reg[0][STS_IRQ_BIT] || $past(irq_clr[0])))
    else $error("interrupt flag not set by edge or dropped without clear");

  clear_held_line_a: assert property (irq_clr[1] && !irq_edge[1] && watch_line[1]
    ##1 watch_line[1] [*2] |-> !sts_reg[1][STS_IRQ_BIT])
    else $error("flag came back without a new edge");

  flush_gates_eot_a: assert property (eot_pending_reg[0] && !engine_evt[0].flushed
    && !stop_wr[0] && !err_set[0] |=> sts_reg[0][STS_ACT_BIT])
    else $error("active cleared before data was flushed");

  reserved_zero_a: assert property (sts_reg[1][7] == 1'b0 && sts_reg[0][4:3] == 2'b00
    && (cmd_reg[0] & ~CMD_WMASK) == 8'h00)
    else $error("reserved bits not zero");

  read_return_a: assert property (io_hit && io_read |=> io_rvalid
    && io_rdata == $past(rd_word))
    else $error("read data not returned next cycle");

  start_sets_sec_a: assert property (s_start_sec |=>
    sts_reg[1][STS_ACT_BIT] && engine_ctl[1].start && engine_ctl[1].run)
    else $error("secondary start did not raise active and start pulse");

  stop_clears_pri_a: assert property (stop_wr[0] |=>
    !sts_reg[0][STS_ACT_BIT] && !engine_ctl[0].run)
    else $error("stop write left primary active");

  irq_edge_sec_a: assert property (irq_edge[1] |=>
    sts_reg[1][STS_IRQ_BIT])
    else $error("secondary interrupt edge did not set the flag");

  clear_held_pri_a: assert property (s_held_clear_pri |->
    !sts_reg[0][STS_IRQ_BIT])
    else $error("primary flag came back without a new edge");

  irq_clear_pri_a: assert property (irq_clr[0] && !irq_edge[0] |=>
    !sts_reg[0][STS_IRQ_BIT])
    else $error("write one did not clear the primary interrupt flag");

  err_clear_sec_a: assert property (err_clr[1] && !err_set[1] |=>
    !sts_reg[1][STS_ERR_BIT])
    else $error("write one did not clear the secondary error flag");

  irq_hold_sec_a: assert property (!irq_edge[1] && !irq_clr[1] |=>
    $stable(sts_reg[1][STS_IRQ_BIT]))
    else $error("secondary interrupt flag moved without edge or clear");

  err_hold_pri_a: assert property (!err_set[0] && !err_clr[0] |=>
    $stable(sts_reg[0][STS_ERR_BIT]))
    else $error("primary error flag moved without abort or clear");

  abort_needs_stop_a: assert property (!stop_wr[1] |=>
    !engine_ctl[1].abort)
    else $error("secondary abort without a stop write");

  start_pulse_one_a: assert property (engine_ctl[0].start |=>
    !engine_ctl[0].start)
    else $error("primary start pulse longer than one cycle");

  start_with_run_a: assert property (!engine_ctl[1].start ||
    engine_ctl[1].run)
    else $error("secondary start pulse without run");

  reserved_sec_a: assert property (sts_reg[0][7] == 1'b0 && sts_reg[1][4:3] == 2'b00
    && (cmd_reg[1] & ~CMD_WMASK) == 8'h00)
    else $error("reserved bits of the other registers not zero");

  read_miss_a: assert property (!(io_hit && io_read) |=>
    !io_rvalid)
    else $error("read valid without a window read");

  act_rise_pri_a: assert property ($rose(sts_reg[0][STS_ACT_BIT]) |->
    $past(start_wr[0]))
    else $error("primary active rose without a start write");

  act_rise_sec_a: assert property ($rose(sts_reg[1][STS_ACT_BIT]) |->
    $past(start_wr[1]))
    else $error("secondary active rose without a start write");

  desc_align_a: assert property (desc_base[0][1:0] == 2'b00
    && desc_base[1][1:0] == 2'b00)
    else $error("descriptor pointer not dword aligned");

endmodule : ide_bm_ctrl

`default_nettype wire

// [dv/ide_far_side.sv]
// Purpose: Far-side model of one descriptor engine and host memory per channel.
// Assumes: The table ends LAT cycles after start; buffered data lands two cycles later.
// Notes: fault_req injects a PCI abort on a running channel.
`timescale 1ns/1ns
`default_nettype none
module ide_far_side
  import ide_bm_pkg::*;
#(parameter int LAT = 12)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and injected faults
  input wire engine_ctl_t [1:0] ctl,
  input wire logic [1:0] fault_req,
  // Engine events
  output wire engine_evt_t [1:0] evt
);
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [3:0] cnt_reg;
    // Stop, abort or restart drops all progress, so nothing is ever resumed
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt_reg <= 4'h0;
      end else if (!ctl[c].run || ctl[c].start || ctl[c].abort) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg != 4'hf) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
    // Data is held back until two cycles after the last region
    assign evt[c].eot_done = ctl[c].run && cnt_reg == 4'(LAT);
    assign evt[c].flushed = !(ctl[c].run && cnt_reg != 4'h0 && cnt_reg <= 4'(LAT + 1));
    assign evt[c].pci_abort = ctl[c].run && fault_req[c];
  end
endmodule : ide_far_side
`default_nettype wire

// [dv/ide_bm_ctrl_bench.sv]
// Purpose: Self-checking bench for the two-channel IDE DMA control registers.
// Assumes: Reads answer one cycle after the strobe.
// Notes: The driver queues expected read data; a monitor matches it on io_rvalid.
`timescale 1ns/1ns
`default_nettype none
module ide_bm_ctrl_bench;
  import ide_bm_pkg::*;
  localparam logic [31:4] BASE = 28'h000_1f00;
  logic clk = 1'b0, rst = 1'b1;
  logic [31:0] io_addr = '0, io_wdata = '0, io_rdata, lfsr = 32'hb3e9_a844;
  logic [3:0] io_be = '0;
  logic io_read = 1'b0, io_write = 1'b0, irq14 = 1'b0, irq15 = 1'b0, bline = 1'b0;
  logic io_hit, io_rvalid;
  logic [7:0] route = '0;
  logic [1:0] fault = '0;
  wire engine_evt_t [1:0] evt;
  engine_ctl_t [1:0] ctl;
  logic [1:0][31:0] dbase;
  logic [31:0] expq[$];
  int n_errors = 0, n_tests = 0, cyc = 0;

  ide_bm_ctrl ide_bm_ctrl_inst (.clk(clk), .rst(rst), .window_base(BASE),
    .io_addr(io_addr), .io_be(io_be), .io_read(io_read), .io_write(io_write),
    .io_wdata(io_wdata), .io_hit(io_hit), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .irq14(irq14), .irq15(irq15), .board_interrupt_line_zero(bline),
    .board_route(route), .engine_evt(evt), .engine_ctl(ctl), .desc_base(dbase));
  ide_far_side #(.LAT(12)) ide_far_side_inst (.clk(clk), .rst(rst), .ctl(ctl),
    .fault_req(fault), .evt(evt));

  always #25 clk = ~clk;

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  // One access: strobe held for exactly one rising edge
  task automatic acc(input logic wr, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge clk);
    io_addr = a;
    io_be = be;
    io_wdata = d;
    io_write = wr;
    io_read = !wr;
    @(negedge clk);
    io_write = 1'b0;
    io_read = 1'b0;
  endtask : acc

  task automatic rd(input logic [3:0] ofs, input logic [3:0] be, input logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, {BASE, ofs}, be, 32'h0000_0000);
  endtask : rd

  task automatic rs(input logic ch, input logic [7:0] e);
    rd({ch, 3'h0}, 4'h4, {8'h00, e, 16'h0000});
  endtask : rs

  task automatic ws(input logic ch, input logic [7:0] v);
    acc(1'b1, {BASE, ch, 3'h0}, 4'h4, {8'h00, v, 16'h0000});
  endtask : ws

  task automatic wc(input logic ch, input logic [7:0] v);
    acc(1'b1, {BASE, ch, 3'h0}, 4'h1, {24'h00_0000, v});
  endtask : wc

  // Read answers are matched in order; one with nothing queued is a fault
  always @(negedge clk) begin
    if (io_rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        check("stray read", 32'h0000_0001, 32'h0000_0000);
      end else begin
        check("read data", io_rdata, expq.pop_front());
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // Reset values, reserved bits, accesses just outside the window
    rd(4'h0, 4'hf, 32'h0000_0000);
    rd(4'hc, 4'hf, 32'h0000_0000);
    wc(1'b0, 8'hf6);
    acc(1'b1, {BASE + 28'h1, 4'h0}, 4'hf, 32'hffff_ffff);
    acc(1'b0, {BASE - 28'h1, 4'h8}, 4'hf, 32'h0000_0000);
    check("miss decode", 32'(io_hit), 32'h0000_0000);
    rd(4'h0, 4'hf, 32'h0000_0000);
    check("hit decode", 32'(io_hit), 32'h0000_0001);
    tend("decode");
    // Start with direction set, then run to end of table
    wc(1'b0, 8'h09);
    check("start", 32'(ctl[0]), 32'h0000_000e);
    @(negedge clk);
    check("run", 32'(ctl[0]), 32'h0000_000c);
    rd(4'h0, 4'h5, 32'h0001_0009);
    ws(1'b0, 8'hff);
    rs(1'b0, 8'h61);
    repeat (20) @(negedge clk);
    rs(1'b0, 8'h60);
    wc(1'b0, 8'h08);
    check("late stop", 32'(ctl[0]), 32'h0000_0008);
    tend("end of table");
    // Stop while data still moves aborts the command
    wc(1'b0, 8'h09);
    wc(1'b0, 8'h08);
    check("abort", 32'(ctl[0]), 32'h0000_0009);
    rs(1'b0, 8'h60);
    tend("abort");
    // Interrupt flag is edge detected; a held line does not set it again
    irq14 = 1'b1;
    rs(1'b0, 8'h64);
    ws(1'b0, 8'h64);
    rs(1'b0, 8'h60);
    irq14 = 1'b0;
    @(negedge clk);
    irq14 = 1'b1;
    rs(1'b0, 8'h64);
    tend("primary interrupt");
    // Secondary follows the board line unless routed to the alternate line
    lfsr = step(lfsr);
    route = lfsr[7:0] & 8'hdf;
    irq15 = 1'b1;
    rs(1'b1, 8'h00);
    bline = 1'b1;
    rs(1'b1, 8'h04);
    ws(1'b1, 8'h04);
    rs(1'b1, 8'h00);
    irq15 = 1'b0;
    route = lfsr[15:8] | 8'h20;
    @(negedge clk);
    irq15 = 1'b1;
    rs(1'b1, 8'h04);
    // A PCI abort on a running channel flags an error and ends activity
    wc(1'b1, 8'h01);
    fault = 2'b10;
    @(negedge clk);
    fault = 2'b00;
    ws(1'b1, 8'h00);
    rs(1'b1, 8'h06);
    ws(1'b1, 8'h06);
    rs(1'b1, 8'h00);
    wc(1'b1, 8'h00);
    check("secondary stop", 32'(ctl[1]), 32'h0000_0000);
    tend("secondary status");
    // Descriptor pointer keeps dword-aligned addresses only
    lfsr = step(lfsr);
    acc(1'b1, {BASE, 4'h4}, 4'hf, lfsr);
    rd(4'h4, 4'hf, lfsr & DTP_MASK);
    check("desc base", dbase[0], lfsr & DTP_MASK);
    check("desc base secondary", dbase[1], 32'h0000_0000);
    tend("pointer");
    repeat (4) @(negedge clk);
    test_done();
  end
endmodule : ide_bm_ctrl_bench
`default_nettype wire
